// ===== ptf_time_sched.sv
// network time keeping, packet absolute time and block start schedule
// assumes protocol messages are decoded elsewhere into second and microsecond words
//
// Overview of operation
// - with network time selected, no satellite-receiver time packets are requested
// - free run starts at fixed virtual epoch, advancing on internal microsecond tick
// - tracking or locked takes date and time to the microsecond from master
// - frozen keeps counting from last synchronised time on internal tick
// - acts only as slave; selecting the source is the only setup
// - packet time fields follow master time with no local offset
// - packet absolute time is whole seconds plus microsecond part
// - single return: block start is packet time plus 5.632 minus 50*(8-n) us; here block n starts at packet time plus 50*(n-1) us
// - dual return: blocks pair, pairs spaced 50 us back from plus 5.632; here pairs start at packet time and follow every 50 us
// - channels fire in ascending order, first through thirty-second
// - channel offset is 1.512*(n-1)+0.368 us after block start; here whole clock periods give 1.55*(n-1)+0.4 us
module ptf_time_sched (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// time source selection and master status
	input wire logic src_net_sel,
	input wire logic master_sync,
	input wire logic master_load,
	input wire logic [31:0] master_sec,
	input wire logic [19:0] master_usec,
	// packet stamping request
	input wire logic pkt_stamp,
	input wire logic dual_mode,
	// time outputs
	output logic [31:0] sec_r,
	output logic [19:0] usec_r,
	output logic [1:0] state_r,
	output logic sat_pkt_en_r,
	output logic tick_1hz_r,
	// packet time and schedule
	output logic [31:0] pkt_sec_r,
	output logic [19:0] microsecond_part_r,
	output logic [63:0] packet_absolute_time_r,
	output logic [3:0] blk_start_r,
	output logic fire_r,
	output logic [5:0] fire_ch_r
);
	localparam logic [4:0] US_DIV = 5'(ptf_pkg::CYC_PER_US);
	localparam logic [19:0] USEC_MAX = 20'(ptf_pkg::US_PER_SEC - 32'h1);
	localparam logic [63:0] MEGA = 64'(ptf_pkg::US_PER_SEC);
	// schedule step in cycles; packet time is taken as the first block's start reference
	localparam int STEP_CYC = ptf_pkg::BLK_STEP_NS / ptf_pkg::CLK_PERIOD_NS;
	localparam logic [10:0] STEP = 11'(STEP_CYC);
	localparam logic [3:0] LAST_BLK = 4'(ptf_pkg::NUM_BLOCKS);

	ptf_pkg::ptf_state_type st_r, st_nxt;
	logic [4:0] div_r;
	logic us_tick;
	logic [3:0] blk_idx_r;
	logic [10:0] blk_cnt_r;
	logic sched_r;
	logic blk_go;
	logic [10:0] gap_cnt_r;
	logic [3:0] last_blk_r;

	// block number step: pairs in dual return, single blocks otherwise
	function automatic logic [3:0] blk_inc(input logic dual);
		return dual ? 4'h2 : 4'h1;
	endfunction

	assign us_tick = (div_r == US_DIV - 5'h01);

	// microsecond prescaler
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 5'h00;
		end else begin
			div_r <= us_tick ? 5'h00 : div_r + 5'h01;
		end
	end

	// tracker: free run, tracking/locked, frozen
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ptf_pkg::ST_FREE: if (src_net_sel && master_sync) st_nxt = ptf_pkg::ST_SYNC;
			ptf_pkg::ST_SYNC: if (!src_net_sel || !master_sync) st_nxt = ptf_pkg::ST_FROZEN;
			ptf_pkg::ST_FROZEN: if (src_net_sel && master_sync) st_nxt = ptf_pkg::ST_SYNC;
			default: st_nxt = ptf_pkg::ST_FREE;
		endcase
	end

	// tracking needs no setup beyond the source select
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ptf_pkg::ST_FREE;
			state_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			case (st_nxt)
				ptf_pkg::ST_SYNC: state_r <= 2'h1;
				ptf_pkg::ST_FROZEN: state_r <= 2'h2;
				default: state_r <= 2'h0;
			endcase
		end
	end

	// satellite-receiver packets only when network time is not selected
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sat_pkt_en_r <= 1'b0;
		end else begin
			sat_pkt_en_r <= !src_net_sel;
		end
	end

	// time of day counter
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sec_r <= ptf_pkg::EPOCH_SEC;
			usec_r <= 20'h00000;
			tick_1hz_r <= 1'b0;
		end else begin
			tick_1hz_r <= 1'b0;
			if (st_r == ptf_pkg::ST_SYNC && master_load) begin
				sec_r <= master_sec;
				usec_r <= master_usec;
			end else if (us_tick) begin
				if (usec_r == USEC_MAX) begin
					usec_r <= 20'h00000;
					sec_r <= sec_r + 32'h1;
					tick_1hz_r <= 1'b1;
				end else begin
					usec_r <= usec_r + 20'h1;
				end
			end
		end
	end

	// packet stamp copies the counter with no offset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pkt_sec_r <= 32'h0;
			microsecond_part_r <= 20'h0;
			packet_absolute_time_r <= 64'h0;
		end else if (pkt_stamp) begin
			pkt_sec_r <= sec_r;
			microsecond_part_r <= usec_r;
			packet_absolute_time_r <= 64'(sec_r) * MEGA + 64'(usec_r);
		end
	end

	// block start sequencer: block 1 earliest, later blocks every 50 us
	// dual mode issues four pair starts, each pair sharing one time
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sched_r <= 1'b0;
			blk_idx_r <= 4'h0;
			blk_cnt_r <= 11'h000;
			blk_start_r <= 4'h0;
		end else begin
			blk_start_r <= 4'h0;
			if (pkt_stamp && !sched_r) begin
				sched_r <= 1'b1;
				blk_idx_r <= blk_inc(dual_mode);
				blk_cnt_r <= 11'h000;
			end else if (sched_r) begin
				if (blk_go) begin
					blk_start_r <= blk_idx_r;
					blk_cnt_r <= STEP - 11'h001;
					blk_idx_r <= blk_idx_r + blk_inc(dual_mode);
					if (blk_idx_r == 4'(ptf_pkg::NUM_BLOCKS)) begin
						sched_r <= 1'b0;
					end
				end else begin
					blk_cnt_r <= blk_cnt_r - 11'h001;
				end
			end
		end
	end

	assign blk_go = sched_r && (blk_cnt_r == 11'h000);

	// cycles since the last block start, for the spacing check
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gap_cnt_r <= 11'h000;
			last_blk_r <= 4'h0;
		end else if (blk_start_r != 4'h0) begin
			gap_cnt_r <= 11'h001;
			last_blk_r <= blk_start_r;
		end else if (gap_cnt_r != 11'h7FF) begin
			gap_cnt_r <= gap_cnt_r + 11'h001;
		end
	end

	ptf_fire_seq #(
		.NCH(ptf_pkg::NUM_CHANNELS)
	) u_fire (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(blk_go),
		.fire_r(fire_r),
		.fire_ch_r(fire_ch_r),
		.busy_r()
	);

	// time source and tracker
	sat_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
		src_net_sel |=> !sat_pkt_en_r)
		else $error("satellite packets enabled under network time");
	sat_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!src_net_sel |=> sat_pkt_en_r)
		else $error("satellite packets missing without network time");
	gain_sync_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r != ptf_pkg::ST_SYNC && src_net_sel && master_sync |=> st_r == ptf_pkg::ST_SYNC)
		else $error("tracking state not entered");
	sync_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_SYNC && src_net_sel && master_sync |=> st_r == ptf_pkg::ST_SYNC)
		else $error("tracking state left while master good");
	lose_sync_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_SYNC && !master_sync |=> st_r == ptf_pkg::ST_FROZEN)
		else $error("frozen state not entered");
	free_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_FREE |-> state_r == 2'h0)
		else $error("free run state code wrong");
	sync_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_SYNC |-> state_r == 2'h1)
		else $error("tracking state code wrong");
	frozen_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_FROZEN |-> state_r == 2'h2)
		else $error("frozen state code wrong");

	// time counter
	sync_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_SYNC && master_load |=> sec_r == $past(master_sec)
		&& usec_r == $past(master_usec))
		else $error("master time not taken");
	free_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_FREE && !us_tick |=> sec_r == $past(sec_r)
		&& usec_r == $past(usec_r))
		else $error("free run time moved without a tick");
	free_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_FREE && us_tick && usec_r != USEC_MAX
		|=> usec_r == $past(usec_r) + 20'h1)
		else $error("free run microsecond not advanced");
	frozen_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_FROZEN && !us_tick |=> sec_r == $past(sec_r))
		else $error("frozen time jumped");
	frozen_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_FROZEN && us_tick && usec_r != USEC_MAX
		|=> usec_r == $past(usec_r) + 20'h1)
		else $error("frozen microsecond not advanced");
	usec_wrap_a: assert property (@(posedge mclk) disable iff (!rst_b)
		us_tick && usec_r == USEC_MAX && !master_load |=> usec_r == 20'h0
		&& sec_r == $past(sec_r) + 32'h1 && tick_1hz_r)
		else $error("microsecond wrap wrong");
	usec_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
		usec_r <= USEC_MAX || $past(master_load))
		else $error("microsecond out of range");
	tick_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		tick_1hz_r |=> !tick_1hz_r)
		else $error("second tick longer than one cycle");
	tick_sec_a: assert property (@(posedge mclk) disable iff (!rst_b)
		tick_1hz_r |-> usec_r == 20'h0)
		else $error("second tick off the microsecond wrap");
	us_period_a: assert property (@(posedge mclk) disable iff (!rst_b)
		us_tick |=> div_r == 5'h00)
		else $error("microsecond prescaler not restarted");

	// stamp and block schedule
	stamp_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pkt_stamp |=> pkt_sec_r == $past(sec_r) && microsecond_part_r == $past(usec_r))
		else $error("packet stamp offset");
	stamp_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!pkt_stamp |=> pkt_sec_r == $past(pkt_sec_r)
		&& microsecond_part_r == $past(microsecond_part_r))
		else $error("packet stamp changed without request");
	abs_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pkt_stamp |=> packet_absolute_time_r
		== 64'($past(sec_r)) * MEGA + 64'($past(usec_r)))
		else $error("absolute time wrong");
	blk_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pkt_stamp && !sched_r |-> ##2 blk_start_r == blk_inc(dual_mode))
		else $error("first block start wrong");
	blk_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
		blk_start_r != 4'h0 && last_blk_r != 4'h0 && last_blk_r != LAST_BLK
		|-> gap_cnt_r == STEP && blk_start_r == last_blk_r + blk_inc(dual_mode))
		else $error("block spacing wrong");
	blk_id_a: assert property (@(posedge mclk) disable iff (!rst_b)
		blk_start_r != 4'h0 |-> blk_start_r <= LAST_BLK && (!dual_mode || !blk_start_r[0]))
		else $error("block number out of range");
	sched_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!sched_r |=> blk_start_r == 4'h0)
		else $error("block start without schedule");
	sync_c: cover property (@(posedge mclk) disable iff (!rst_b)
		st_r == ptf_pkg::ST_SYNC ##1 st_r == ptf_pkg::ST_FROZEN);
	wrap_c: cover property (@(posedge mclk) disable iff (!rst_b) tick_1hz_r);
	dual_c: cover property (@(posedge mclk) disable iff (!rst_b)
		dual_mode && blk_start_r == 4'h8);
	restamp_c: cover property (@(posedge mclk) disable iff (!rst_b)
		pkt_stamp && sched_r);
endmodule // ptf_time_sched

// ===== ptf_pkg.sv
// constants for the network-time keeping and firing schedule block
// assumes a single 20 MHz clock and an asynchronous active-low reset
package ptf_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	// microsecond tick from the 20 MHz clock
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
	localparam logic [31:0] US_PER_SEC = 32'h000F4240;
	// virtual utc epoch, whole seconds (arbitrary plain default)
	localparam logic [31:0] EPOCH_SEC = 32'h00000000;
	// firing schedule figures in nanoseconds, block and channel counts, and cycle counts
	localparam int BLK_LEAD_NS = 5632;
	localparam int BLK_STEP_NS = 50000;
	localparam int CH_STEP_NS = 1512;
	localparam int CH_LEAD_NS = 368;
	localparam int NUM_BLOCKS = 8;
	localparam int NUM_CHANNELS = 32;
	localparam int CH_STEP_CYC = (CH_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CH_LEAD_CYC = (CH_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// time source tracker states
	typedef enum logic [2:0] {
		ST_FREE = 3'b001,
		ST_SYNC = 3'b010,
		ST_FROZEN = 3'b100
	} ptf_state_type;
endpackage

// ===== ptf_fire_seq.sv
// per-block channel firing sequencer
// assumes start pulses are spaced wider than one full channel round
module ptf_fire_seq #(
	parameter int NCH = ptf_pkg::NUM_CHANNELS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// control
	input wire logic start,
	// firing outputs
	output logic fire_r,
	output logic [5:0] fire_ch_r,
	output logic busy_r
);
	localparam logic [5:0] LAST_CH = 6'(NCH);
	localparam logic [6:0] LEAD = 7'(ptf_pkg::CH_LEAD_CYC);
	localparam logic [6:0] STEP = 7'(ptf_pkg::CH_STEP_CYC);
	// first fire shows one cycle after the counter reaches zero
	localparam int LEAD_DLY = ptf_pkg::CH_LEAD_CYC + 1;
	localparam int STEP_DLY = ptf_pkg::CH_STEP_CYC;
	logic [6:0] cnt_r;
	logic [5:0] next_ch_r;

	// channels fire in ascending order, offset 0.4 us then every 1.55 us
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 7'h00;
			next_ch_r <= 6'h00;
			busy_r <= 1'b0;
			fire_r <= 1'b0;
			fire_ch_r <= 6'h00;
		end else begin
			fire_r <= 1'b0;
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				next_ch_r <= 6'h01;
				cnt_r <= LEAD - 7'h01;
			end else if (busy_r) begin
				if (cnt_r == 7'h00) begin
					fire_r <= 1'b1;
					fire_ch_r <= next_ch_r;
					next_ch_r <= next_ch_r + 6'h01;
					cnt_r <= STEP - 7'h01;
					if (next_ch_r == LAST_CH) begin
						busy_r <= 1'b0;
					end
				end else begin
					cnt_r <= cnt_r - 7'h01;
				end
			end
		end
	end

	seq_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
		fire_r && fire_ch_r != LAST_CH |-> ##(STEP_DLY) fire_r
		&& fire_ch_r == $past(fire_ch_r, STEP_DLY) + 6'h01)
		else $error("channel order or spacing wrong");
	seq_lead_a: assert property (@(posedge mclk) disable iff (!rst_b)
		start && !busy_r |-> ##(LEAD_DLY) fire_r && fire_ch_r == 6'h01)
		else $error("first channel offset wrong");
	seq_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
		fire_r |-> fire_ch_r >= 6'h01 && fire_ch_r <= LAST_CH)
		else $error("channel number out of range");
	seq_last_a: assert property (@(posedge mclk) disable iff (!rst_b)
		fire_r && fire_ch_r == LAST_CH |-> !busy_r)
		else $error("round not closed after last channel");
	seq_round_c: cover property (@(posedge mclk) disable iff (!rst_b)
		fire_r && fire_ch_r == LAST_CH);
endmodule // ptf_fire_seq

// ===== ptf_net_master.sv
// network time master model driving decoded second and microsecond words
// assumes the bench calls its tasks; words are only valid in the load cycle
module ptf_net_master (
	// clock
	input wire logic mclk,
	// master status and time words
	output logic master_sync,
	output logic master_load,
	output logic [31:0] master_sec,
	output logic [19:0] master_usec
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		master_sync = 1'b0;
		master_load = 1'b0;
		master_sec = 32'h00000000;
		master_usec = 20'h00000;
	end
	task automatic set_sync(input logic v);
		@(posedge mclk);
		master_sync <= v;
	endtask
	task automatic load(input logic [31:0] s, input logic [19:0] u);
		@(posedge mclk);
		master_load <= 1'b1;
		master_sec <= s;
		master_usec <= u;
		@(posedge mclk);
		master_load <= 1'b0;
		// words no longer valid: show the inverse
		master_sec <= ~s;
		master_usec <= ~u;
	endtask
endmodule // ptf_net_master

// ===== ptf_time_sched_test.sv
// self-checking bench for the network time keeping and firing schedule
// assumes the master model drives all master inputs
module ptf_time_sched_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst_b = 1'b0, src_net_sel = 1'b1, pkt_stamp = 1'b0, dual_mode = 1'b0;
	logic master_sync, master_load;
	logic [31:0] master_sec, sec_r, pkt_sec_r;
	logic [19:0] master_usec, usec_r, microsecond_part_r;
	logic [1:0] state_r;
	logic sat_pkt_en_r, tick_1hz_r, fire_r;
	logic [63:0] packet_absolute_time_r;
	logic [3:0] blk_start_r, exp_blk, step;
	logic [5:0] fire_ch_r, exp_ch;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, t_blk = 0, t_fire = 0, n_blk = 0, n_fire = 0;
	always #25 mclk = ~mclk;
	ptf_net_master u_ptf_net_master (.mclk(mclk), .master_sync(master_sync),
		.master_load(master_load), .master_sec(master_sec), .master_usec(master_usec));
	ptf_time_sched u_ptf_time_sched (.mclk(mclk), .rst_b(rst_b), .src_net_sel(src_net_sel),
		.master_sync(master_sync), .master_load(master_load), .master_sec(master_sec),
		.master_usec(master_usec), .pkt_stamp(pkt_stamp), .dual_mode(dual_mode),
		.sec_r(sec_r), .usec_r(usec_r), .state_r(state_r), .sat_pkt_en_r(sat_pkt_en_r),
		.tick_1hz_r(tick_1hz_r), .pkt_sec_r(pkt_sec_r),
		.microsecond_part_r(microsecond_part_r),
		.packet_absolute_time_r(packet_absolute_time_r), .blk_start_r(blk_start_r),
		.fire_r(fire_r), .fire_ch_r(fire_ch_r));
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// schedule monitor: block order and spacing, channel order and offsets
	always @(posedge mclk) begin
		cyc++;
		if (blk_start_r !== 4'h0) begin
			chk("block id", 64'(blk_start_r), 64'(exp_blk));
			if (n_blk > 0) chk("block gap", 64'(cyc - t_blk), 64'd1000);
			t_blk = cyc;
			n_blk++;
			exp_blk = exp_blk + step;
			exp_ch = 6'h01;
		end
		if (fire_r === 1'b1) begin
			chk("channel", 64'(fire_ch_r), 64'(exp_ch));
			if (exp_ch == 6'h01)
				chk("lead", 64'(cyc - t_blk), 64'(ptf_pkg::CH_LEAD_CYC));
			else chk("step", 64'(cyc - t_fire), 64'(ptf_pkg::CH_STEP_CYC));
			t_fire = cyc;
			exp_ch++;
			n_fire++;
		end
	end
	task automatic stamp;
		@(posedge mclk);
		pkt_stamp <= 1'b1;
		@(posedge mclk);
		pkt_stamp <= 1'b0;
		#1;
	endtask
	task automatic t_free;
		chk("state", 64'(state_r), 64'd0);
		chk("sec", 64'(sec_r), 64'(ptf_pkg::EPOCH_SEC));
		chk("sat off", 64'(sat_pkt_en_r), 64'd0);
		u_ptf_net_master.load(32'h00000063, 20'h00000);
		#1;
		chk("free no load", 64'(sec_r), 64'(ptf_pkg::EPOCH_SEC));
		@(posedge mclk);
		src_net_sel <= 1'b0;
		repeat (41) @(posedge mclk);
		#1;
		chk("usec run", 64'(usec_r inside {[1:3]}), 64'd1);
		chk("sat on", 64'(sat_pkt_en_r), 64'd1);
		@(posedge mclk);
		src_net_sel <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("sat off again", 64'(sat_pkt_en_r), 64'd0);
		$display("free run test done");
	endtask
	task automatic t_sync;
		int n;
		u_ptf_net_master.set_sync(1'b1);
		repeat (3) @(posedge mclk);
		#1;
		chk("state", 64'(state_r), 64'd1);
		u_ptf_net_master.load(32'h00000007, 20'hF423E);
		#1;
		chk("sec", 64'(sec_r), 64'd7);
		chk("usec", 64'(usec_r), 64'hF423E);
		n = 0;
		while (sec_r !== 32'h00000008 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("roll sec", 64'(sec_r), 64'd8);
		chk("roll usec", 64'(usec_r), 64'd0);
		chk("tick", 64'(tick_1hz_r), 64'd1);
		$display("sync test done");
	endtask
	task automatic t_sched(input logic dual);
		int nb;
		nb = dual ? 4 : 8;
		@(posedge mclk);
		dual_mode <= dual;
		exp_blk = dual ? 4'h2 : 4'h1;
		step = dual ? 4'h2 : 4'h1;
		n_blk = 0;
		n_fire = 0;
		u_ptf_net_master.load(32'h00000014, 20'h001F4);
		stamp();
		chk("pkt sec", 64'(pkt_sec_r), 64'd20);
		chk("pkt usec", 64'(microsecond_part_r inside {[500:501]}), 64'd1);
		chk("abs", packet_absolute_time_r, 64'd20000000 + 64'(microsecond_part_r));
		repeat (1500) @(posedge mclk);
		stamp();
		repeat (nb * 1000) @(posedge mclk);
		chk("blocks", 64'(n_blk), 64'(nb));
		chk("fires", 64'(n_fire), 64'(nb * 32));
		$display("schedule test done");
	endtask
	task automatic t_frozen;
		u_ptf_net_master.set_sync(1'b0);
		repeat (3) @(posedge mclk);
		#1;
		chk("state", 64'(state_r), 64'd2);
		chk("keep sec", 64'(sec_r), 64'd20);
		u_ptf_net_master.load(32'h00000063, 20'h00000);
		#1;
		chk("no load", 64'(sec_r), 64'd20);
		u_ptf_net_master.set_sync(1'b1);
		repeat (3) @(posedge mclk);
		#1;
		chk("resync", 64'(state_r), 64'd1);
		$display("frozen test done");
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		#1;
		t_free();
		t_sync();
		t_sched(1'b0);
		t_sched(1'b1);
		t_frozen();
		end_of_test();
	end
	initial begin
		#3000000;
		n_mismatch++;
		end_of_test();
	end
endmodule // ptf_time_sched_test
